// ===== pcs_pkg.sv
package pcs_pkg;

  // ------------------------------------------------------------------
  // Configuration word placement
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [5:0] CMD_DWORD  = CMD_OFFSET[7:2];

  // ------------------------------------------------------------------
  // Command word bit positions
  // ------------------------------------------------------------------
  localparam int CMD_IO       = 0;
  localparam int CMD_MEM      = 1;
  localparam int CMD_BM       = 2;
  localparam int CMD_MWI      = 4;
  localparam int CMD_PAR_RESP = 6;
  localparam int CMD_SERR_EN  = 8;
  localparam int CMD_B2B      = 9;
  localparam int CMD_INT_DIS  = 10;

  // ------------------------------------------------------------------
  // Implementation choices for optional command bits
  // ------------------------------------------------------------------
  localparam logic IO_SPACE_RW = 1'b0;
  localparam logic B2B_RW      = 1'b1;
  localparam logic SERR_EN_RW  = 1'b1;
  localparam logic PAR_RESP_RW = 1'b1;
  localparam logic MWI_RW      = 1'b1;

  localparam logic [15:0] CMD_WMASK = {5'h00, 1'b1, B2B_RW, SERR_EN_RW,
                                       1'b0, PAR_RESP_RW, 1'b0, MWI_RW,
                                       1'b0, 1'b1, 1'b1, IO_SPACE_RW};
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // Status word constants
  // ------------------------------------------------------------------
  localparam logic [1:0] DEVSEL_CLASS = 2'h1;
  localparam logic       B2B_CAPABLE  = 1'b0;
  localparam logic       FREQ_CAPABLE = 1'b0;
  localparam logic       CAP_LIST     = 1'b1;

  // Sticky flag indices: status bit 8, then bits 11 to 15.
  localparam int NUM_FLAGS = 6;
  localparam int FL_MPE      = 0;
  localparam int FL_TABT_SIG = 1;
  localparam int FL_TABT_RCV = 2;
  localparam int FL_MABT_RCV = 3;
  localparam int FL_SERR_SIG = 4;
  localparam int FL_PAR_DET  = 5;
  localparam logic [NUM_FLAGS-1:0] FLAG_RESET = 6'h00;

  // ------------------------------------------------------------------
  // Module state types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic        int_stat;
    logic        ack;
    logic [31:0] rdata;
    logic        dma_halt;
  } pcs_top_state_t;

  typedef struct packed {
    logic [NUM_FLAGS-1:0] flag;
  } pcs_flag_state_t;

  typedef struct packed {
    logic inta_oe;
    logic serr_oe;
    logic perr_oe;
    logic pin_out;
  } pcs_pin_state_t;

endpackage : pcs_pkg

// ===== pcs_flag_if.sv
`timescale 1ns/1ns
interface pcs_flag_if
  import pcs_pkg::*;
;
  logic [NUM_FLAGS-1:0] set;
  logic [NUM_FLAGS-1:0] clr;
  logic [NUM_FLAGS-1:0] flag;
  modport owner (input set, input clr, output flag);
  modport user  (output set, output clr, input flag);
endinterface : pcs_flag_if

// ===== pcs_flags.sv
`timescale 1ns/1ns
module pcs_flags
  import pcs_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  pcs_flag_if.owner   fl
);

  pcs_flag_state_t st;
  pcs_flag_state_t next_st;

  // ------------------------------------------------------------------
  // Sticky write-one-to-clear flags
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      // RULE20: zero write keeps
      // A set in the same cycle as a clear wins.
      if (fl.set[i]) begin
        next_st.flag[i] = 1'b1;
      end else if (fl.clr[i]) begin
        next_st.flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st.flag <= FLAG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign fl.flag = st.flag;

endmodule : pcs_flags

// ===== pcs_pins.sv
`timescale 1ns/1ns
module pcs_pins
  import pcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic par_resp,
  input  wire logic serr_en,
  input  wire logic int_disable,
  input  wire logic msi_enable,
  input  wire logic int_req,
  input  wire logic perr_event,
  input  wire logic serr_event,
  output logic      inta_oe,
  output logic      serr_oe,
  output logic      perr_oe,
  output logic      pin_out
);

  pcs_pin_state_t st;
  pcs_pin_state_t next_st;

  // ------------------------------------------------------------------
  // Open-drain pin drivers
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_out = 1'b0;
    // RULE1: disable pin interrupt
    next_st.inta_oe = int_req & ~int_disable & ~msi_enable;
    // RULE3: gated error line
    next_st.serr_oe = serr_event & serr_en;
    // RULE4: parity error line
    next_st.perr_oe = perr_event & par_resp;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign inta_oe = st.inta_oe;
  assign serr_oe = st.serr_oe;
  assign perr_oe = st.perr_oe;
  assign pin_out = st.pin_out;

endmodule : pcs_pins

// ===== pcs_cmd_status.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: interrupt disable blocks pin interrupt, not MSI
// RULE2: fast back-to-back only when enabled
// RULE3: error line driven only when enabled
// RULE4: parity response enable drives parity line
// RULE5: write-invalidate only when enabled
// RULE6: clearing master enable halts DMA engines
// RULE7: memory space enable gates decode, reset zero
// RULE8: I/O enable writable only with legacy IDE
// RULE9: reserved command bits read zero
// RULE10: parity detected flag sticky, write-one-clear
// RULE11: system error signalled flag sticky
// RULE12: master abort received flag sticky
// RULE13: target abort received flag sticky
// RULE14: target abort signalled flag sticky
// RULE15: master parity flag needs parity response
// RULE16: select timing class read-only
// RULE17: capability bits 7 and 5 read-only
// RULE18: capability list present reads one
// RULE19: interrupt status shows interrupt; reserved zero
// RULE20: zero writes keep flags; status ignores disable
module pcs_cmd_status
  import pcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  input  wire logic        evt_parity_detect,
  input  wire logic        evt_data_parity,
  input  wire logic        evt_master_parity,
  input  wire logic        evt_master_abort,
  input  wire logic        evt_target_abort_rcv,
  input  wire logic        evt_target_abort_sig,
  input  wire logic        evt_serr,
  input  wire logic        int_req,
  input  wire logic        msi_enable,
  output logic             inta_n_out,
  output logic             inta_n_oe,
  output logic             serr_n_out,
  output logic             serr_n_oe,
  output logic             perr_n_out,
  output logic             perr_n_oe,
  output logic             bus_master_en,
  output logic             mem_space_en,
  output logic             io_space_en,
  output logic             fast_b2b_en,
  output logic             mwi_en,
  output logic             dma_halt
);

  pcs_top_state_t st;
  pcs_top_state_t next_st;

  logic            hit;
  logic [15:0]     lane_mask;
  logic [15:0]     status_word;
  logic            pin_out;

  pcs_flag_if      flags_if ();

  // ------------------------------------------------------------------
  // Sticky status flags
  // ------------------------------------------------------------------
  pcs_flags u_flags (
    .clk   (clk),
    .rst_b (rst_b),
    .fl    (flags_if)
  );

  // ------------------------------------------------------------------
  // Interrupt and error pins
  // ------------------------------------------------------------------
  pcs_pins u_pins (
    .clk         (clk),
    .rst_b       (rst_b),
    .par_resp    (st.cmd[CMD_PAR_RESP]),
    .serr_en     (st.cmd[CMD_SERR_EN]),
    .int_disable (st.cmd[CMD_INT_DIS]),
    .msi_enable  (msi_enable),
    .int_req     (int_req),
    .perr_event  (evt_data_parity),
    .serr_event  (evt_serr),
    .inta_oe     (inta_n_oe),
    .serr_oe     (serr_n_oe),
    .perr_oe     (perr_n_oe),
    .pin_out     (pin_out)
  );

  assign inta_n_out = pin_out;
  assign serr_n_out = pin_out;
  assign perr_n_out = pin_out;

  // ------------------------------------------------------------------
  // Flag set and clear terms
  // ------------------------------------------------------------------
  assign hit = cfg_req & (cfg_addr[7:2] == CMD_DWORD);

  always_comb begin
    flags_if.set = '0;
    flags_if.clr = '0;
    // RULE10: detected parity sets
    flags_if.set[FL_PAR_DET] = evt_parity_detect;
    // RULE11: set when line driven
    flags_if.set[FL_SERR_SIG] = serr_n_oe;
    // RULE12: master abort sets
    flags_if.set[FL_MABT_RCV] = evt_master_abort;
    // RULE13: target abort received
    flags_if.set[FL_TABT_RCV] = evt_target_abort_rcv;
    // RULE14: target abort signalled
    flags_if.set[FL_TABT_SIG] = evt_target_abort_sig;
    // RULE15: gated by parity response
    flags_if.set[FL_MPE] = evt_master_parity & st.cmd[CMD_PAR_RESP];
    if (hit && cfg_we && cfg_be[3]) begin
      // RULE20: only ones clear
      flags_if.clr[FL_MPE]      = cfg_wdata[24];
      flags_if.clr[FL_TABT_SIG] = cfg_wdata[27];
      flags_if.clr[FL_TABT_RCV] = cfg_wdata[28];
      flags_if.clr[FL_MABT_RCV] = cfg_wdata[29];
      flags_if.clr[FL_SERR_SIG] = cfg_wdata[30];
      flags_if.clr[FL_PAR_DET]  = cfg_wdata[31];
    end
  end

  // ------------------------------------------------------------------
  // Status word assembly
  // ------------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[15] = flags_if.flag[FL_PAR_DET];
    status_word[14] = flags_if.flag[FL_SERR_SIG];
    status_word[13] = flags_if.flag[FL_MABT_RCV];
    status_word[12] = flags_if.flag[FL_TABT_RCV];
    status_word[11] = flags_if.flag[FL_TABT_SIG];
    // RULE16: fixed timing class
    status_word[10:9] = DEVSEL_CLASS;
    status_word[8] = flags_if.flag[FL_MPE];
    // RULE17: fixed capability bits
    status_word[7] = B2B_CAPABLE;
    status_word[5] = FREQ_CAPABLE;
    // RULE18: capability list present
    status_word[4] = CAP_LIST;
    // RULE19: interrupt status bit
    status_word[3] = st.int_stat;
  end

  // ------------------------------------------------------------------
  // Command word writes and read answers
  // ------------------------------------------------------------------
  // Only bits in the write mask take a value, so reserved and read-only
  // command bits stay at their reset value whatever software writes.
  assign lane_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & CMD_WMASK;

  always_comb begin
    next_st = st;
    next_st.ack = cfg_req;
    // RULE20: follows raw request
    next_st.int_stat = int_req;
    if (hit && cfg_we) begin
      // RULE9: reserved bits masked
      // RULE8: I/O bit per mask
      next_st.cmd = (st.cmd & ~lane_mask) | (cfg_wdata[15:0] & lane_mask);
    end
    if (cfg_req && !cfg_we) begin
      next_st.rdata = hit ? {status_word, st.cmd} : 32'h0000_0000;
    end
    // RULE6: halt DMA engines
    next_st.dma_halt = ~next_st.cmd[CMD_BM];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st.cmd      <= CMD_RESET;
      st.int_stat <= 1'b0;
      st.ack      <= 1'b0;
      st.rdata    <= 32'h0000_0000;
      st.dma_halt <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cfg_ack   = st.ack;
  assign cfg_rdata = st.rdata;
  // RULE6: master enable out
  assign bus_master_en = st.cmd[CMD_BM];
  assign dma_halt      = st.dma_halt;
  // RULE7: memory decode enable
  assign mem_space_en  = st.cmd[CMD_MEM];
  // RULE8: I/O decode enable
  assign io_space_en   = st.cmd[CMD_IO];
  // RULE2: back-to-back enable
  assign fast_b2b_en   = st.cmd[CMD_B2B];
  // RULE5: write-invalidate enable
  assign mwi_en        = st.cmd[CMD_MWI];

endmodule : pcs_cmd_status

// ===== pcs_cmd_status_checker.sv
`timescale 1ns/1ns
module pcs_cmd_status_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cfg_req,
  input wire logic cfg_ack,
  input wire logic evt_serr,
  input wire logic evt_data_parity,
  input wire logic int_req,
  input wire logic msi_enable,
  input wire logic inta_n_out,
  input wire logic inta_n_oe,
  input wire logic serr_n_out,
  input wire logic serr_n_oe,
  input wire logic perr_n_oe,
  input wire logic bus_master_en,
  input wire logic io_space_en,
  input wire logic dma_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    cfg_req;
  endsequence
  sequence s_ack;
    ##1 cfg_ack;
  endsequence
  a_ack_after_req: assert property (s_req |-> s_ack)
    else $error("no ack after request");
  a_serr_gate: assert property (serr_n_oe |-> $past(evt_serr))
    else $error("error line without event");
  a_serr_low: assert property (serr_n_oe |-> !serr_n_out)
    else $error("error line not driven low");
  a_perr_gate: assert property (perr_n_oe |-> $past(evt_data_parity))
    else $error("parity line without event");
  a_int_gate: assert property (inta_n_oe |->
    $past(int_req) && !$past(msi_enable))
    else $error("pin interrupt without cause");
  a_int_low: assert property (inta_n_oe |-> !inta_n_out)
    else $error("interrupt pin not driven low");
  a_halt_tracks: assert property (dma_halt == !bus_master_en)
    else $error("halt does not follow master enable");
  a_io_fixed: assert property (!io_space_en)
    else $error("io enable became set");
endmodule : pcs_cmd_status_checker

bind pcs_cmd_status pcs_cmd_status_checker i_chk (
  .clk(clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
  .evt_serr(evt_serr), .evt_data_parity(evt_data_parity),
  .int_req(int_req), .msi_enable(msi_enable), .inta_n_out(inta_n_out),
  .inta_n_oe(inta_n_oe), .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe),
  .perr_n_oe(perr_n_oe), .bus_master_en(bus_master_en),
  .io_space_en(io_space_en), .dma_halt(dma_halt));

// ===== pcs_bus_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Host bus lines with pull-ups
// ------------------------------------------------------------------
module pcs_bus_model (
  input  wire logic [2:0] oe,
  input  wire logic [2:0] dout,
  output logic      [2:0] line_n
);
  assign line_n = (oe & dout) | ~oe;
endmodule : pcs_bus_model

// ===== testbench.sv
`timescale 1ns/1ns
module testbench
  import pcs_pkg::*;
;
  logic        clk, rst_b, req, we, irq, msi;
  wire         ack;
  logic [3:0]  be;
  logic [7:0]  addr;
  logic [31:0] wd, got;
  wire  [31:0] rd;
  logic [6:0]  ev;
  wire  [2:0]  oe, dout, line_n;
  wire  [5:0]  en;
  int err_count, total_checks;
  localparam logic [15:0] SB = {5'h00, DEVSEL_CLASS, 1'b0, B2B_CAPABLE,
    1'b0, FREQ_CAPABLE, CAP_LIST, 4'h0};

  pcs_cmd_status i_dut (.clk(clk), .rst_b(rst_b), .cfg_req(req),
    .cfg_we(we), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd),
    .cfg_ack(ack), .cfg_rdata(rd), .evt_parity_detect(ev[6]),
    .evt_data_parity(ev[5]), .evt_master_parity(ev[4]),
    .evt_master_abort(ev[3]), .evt_target_abort_rcv(ev[2]),
    .evt_target_abort_sig(ev[1]), .evt_serr(ev[0]), .int_req(irq),
    .msi_enable(msi), .inta_n_out(dout[2]), .inta_n_oe(oe[2]),
    .serr_n_out(dout[1]), .serr_n_oe(oe[1]), .perr_n_out(dout[0]),
    .perr_n_oe(oe[0]), .bus_master_en(en[5]), .mem_space_en(en[4]),
    .io_space_en(en[3]), .fast_b2b_en(en[2]), .mwi_en(en[1]),
    .dma_halt(en[0]));
  pcs_bus_model i_bus (.oe(oe), .dout(dout), .line_n(line_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    int n;
    {req, we, addr, be, wd} = {1'b1, w, a, b, d};
    @(posedge clk);
    #1 req = 1'b0;
    for (n = 0; n < 4 && ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (ack !== 1'b1) begin
      err_count++;
      close_out();
    end
    got = rd;
    // Let one edge pass so that the next request is a fresh pulse.
    @(posedge clk);
    #1;
  endtask : cfg

  task automatic pulse(input logic [6:0] v);
    ev = v;
    @(posedge clk);
    #1 ev = 7'h00;
    got = {29'h0, line_n};
    @(posedge clk);
    #1;
  endtask : pulse

  task automatic t_reset;
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("reset word", {SB, CMD_RESET}, got);
    chk("halt", 32'h1, {31'h0, en[0]});
    cfg(1'b0, 8'h08, 4'hf, 32'h0);
    chk("unmapped", 32'h0, got);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cmd;
    cfg(1'b1, CMD_OFFSET, 4'hf, 32'hffff_ffff);
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("cmd ones", {SB, CMD_WMASK}, got);
    chk("enables", 32'h36, {26'h0, en});
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0);
    chk("halted", 32'h1, {26'h0, en});
    $display("test command done");
  endtask : t_cmd

  task automatic t_flags;
    pulse(7'h7f);
    chk("no lines", 32'h7, got);
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("gated flags", {SB | 16'hb800, 16'h0}, got);
    cfg(1'b1, CMD_OFFSET, 4'h8, 32'hff00_0000);
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0140);
    pulse(7'h7f);
    chk("lines low", 32'h4, got);
    cfg(1'b1, CMD_OFFSET, 4'h8, 32'h0);
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("all flags", {SB | 16'hf900, 16'h0140}, got);
    cfg(1'b1, CMD_OFFSET, 4'h8, 32'hff00_0000);
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("cleared", {SB, 16'h0140}, got);
    $display("test flags done");
  endtask : t_flags

  task automatic t_irq;
    irq = 1'b1;
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0);
    chk("pin on", 32'h3, {29'h0, line_n});
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0400);
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("status on", {SB | 16'h0008, 16'h0400}, got);
    chk("pin off", 32'h7, {29'h0, line_n});
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0);
    msi = 1'b1;
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("msi pin", 32'h7, {29'h0, line_n});
    {irq, msi} = 2'b00;
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_race;
    fork
      cfg(1'b1, CMD_OFFSET, 4'h8, 32'hff00_0000);
      pulse(7'h08);
    join
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("set wins", {SB | 16'h2000, 16'h0}, got);
    cfg(1'b1, CMD_OFFSET, 4'h3, 32'h0006);
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    cfg(1'b0, CMD_OFFSET, 4'hf, 32'h0);
    chk("reset again", {SB, CMD_RESET}, got);
    chk("halt again", 32'h1, {31'h0, en[0]});
    $display("test race and reset done");
  endtask : t_race

  initial begin
    {rst_b, req, we, irq, msi, be, addr, wd, ev} = '0;
    err_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_cmd();
    t_flags();
    t_irq();
    t_race();
    close_out();
  end
endmodule : testbench
